// >>> logic/atsx_top.sv
// ats multi-translation completions, translated request checks, device-tlb invalidation tags
`timescale 1ns/10ps
// Overview of operation
// - length above two doublewords means the request asks for several mappings
// - single mode translates start only: length 2, byte count 8, low address rcb-8
// - multi mode fetches onward, stops at CA, UR or a page size change
// - multi mode also stops at a cache line worth of translations
// - each returned translation abuts the untranslated range of the previous one
// - with remapping on, a translated request with pasid prefix is malformed
// - translated write or atomic to the interrupt window completes as UR
// - any read to the interrupt window that is not malformed completes as UR
// - failed table check blocks the request as V_FAULT and records a fault
// - root entry fetch error, not present or reserved bits set blocks
// - context entry fetch error, not present or reserved bits set blocks
// - unsupported address width or translation type in context entry blocks
// - translation type selecting blocking of translated requests blocks
// - with no blocking condition the request passes untranslated
// - each invalidation takes a free tag, or waits until one frees
// - each allocated tag keeps a count of its completion messages
// - allocation starts the tag timer and sends the message, pasid for first level
// - invalidation time-out sits well above the read completion time-out
// - tag not owned by source drops message, sets error flag, maybe fault event
// - valid tags count up; match with count (0 means 8) completes and frees
// - timer expiry frees tag, sets time-out flag, maybe fault event
module atsx_top
#(
   parameter logic [31:0] TMO_CYCLES = 32'(atsx_pkg::INV_TMO_CYC)
)
(
   input  wire logic                                 aclk,
   input  wire logic                                 aresetn,
   input  wire logic                                 ce,
   input  wire logic [7:0]                           s_axi_awaddr,
   input  wire logic                                 s_axi_awvalid,
   output logic                                      s_axi_awready,
   input  wire logic [31:0]                          s_axi_wdata,
   input  wire logic [3:0]                           s_axi_wstrb,
   input  wire logic                                 s_axi_wvalid,
   output logic                                      s_axi_wready,
   output logic [1:0]                                s_axi_bresp,
   output logic                                      s_axi_bvalid,
   input  wire logic                                 s_axi_bready,
   input  wire logic [7:0]                           s_axi_araddr,
   input  wire logic                                 s_axi_arvalid,
   output logic                                      s_axi_arready,
   output logic [31:0]                               s_axi_rdata,
   output logic [1:0]                                s_axi_rresp,
   output logic                                      s_axi_rvalid,
   input  wire logic                                 s_axi_rready,
   input  wire logic                                 xreq_valid,
   output logic                                      xreq_ready,
   input  wire atsx_pkg::atsx_xreq_t                 xreq,
   output logic                                      look_valid,
   input  wire logic                                 look_ready,
   output logic [63:0]                               look_addr,
   input  wire logic                                 look_rsp_valid,
   input  wire atsx_pkg::atsx_lrsp_t                 look_rsp,
   output logic                                      ent_valid,
   input  wire logic                                 ent_ready,
   output atsx_pkg::atsx_ent_t                       ent,
   output logic                                      hdr_valid,
   input  wire logic                                 hdr_ready,
   output atsx_pkg::atsx_hdr_t                       hdr,
   input  wire logic                                 trq_valid,
   input  wire atsx_pkg::atsx_trq_t                  trq,
   input  wire atsx_pkg::atsx_tchk_t                 tchk,
   output logic                                      tv_valid,
   output atsx_pkg::atsx_verd_t                      tv_verdict,
   output logic                                      fault_rec,
   input  wire logic                                 ireq_valid,
   output logic                                      ireq_ready,
   input  wire atsx_pkg::atsx_ireq_t                 ireq,
   output logic                                      imsg_valid,
   input  wire logic                                 imsg_ready,
   output atsx_pkg::atsx_imsg_t                      imsg,
   input  wire logic                                 icpl_valid,
   input  wire atsx_pkg::atsx_icpl_t                 icpl,
   output logic [atsx_pkg::NTAG-1:0]                 done_vec,
   output logic                                      fault_event
);
   localparam int NT = atsx_pkg::NTAG;

   typedef struct packed
   {
      logic aw_v;
      logic [7:0] aw_a;
      logic w_v;
      logic [31:0] w_d;
      logic [3:0] w_s;
      logic b_v;
      logic [1:0] b_r;
      logic r_v;
      logic [31:0] r_d;
      logic [1:0] r_r;
      logic [31:0] ctrl;
      logic inval_completion_error_flag;
      logic inval_timeout_error_flag;
      logic tf;
      atsx_pkg::atsx_xst_t xs;
      logic [63:0] cur;
      logic [3:0] cnt;
      logic [9:0] want;
      logic [7:0] read_completion_boundary;
      logic sgl;
      atsx_pkg::atsx_cst_t st;
      atsx_pkg::atsx_ent_t ent;
      atsx_pkg::atsx_hdr_t hdr;
      logic tv_v;
      atsx_pkg::atsx_verd_t verd;
      logic frec;
      logic [NT-1:0] busy;
      logic [NT-1:0][15:0] own;
      logic [NT-1:0][3:0] icnt;
      logic [NT-1:0][31:0] tmr;
      logic mp;
      atsx_pkg::atsx_imsg_t msg;
      logic [NT-1:0] done;
      logic fev;
   } atsx_st_t;

   atsx_st_t r_r;
   atsx_st_t r_nxt;
   logic [NT-1:0] hit;
   logic          bad;
   logic [3:0]    cc_eff;

   // interrupt window decode, shared by checks and assertions
   function automatic logic in_intr(input logic [63:0] a);
      in_intr = (a[63:32] == 32'h0) && (a[31:20] == atsx_pkg::INTR_WIN);
   endfunction

   // any failing root or context table check
   function automatic logic tbl_fail(input atsx_pkg::atsx_tchk_t t);
      tbl_fail = t.root_err || !t.root_present || t.root_rsvd
         || t.ctx_err || !t.ctx_present || t.ctx_rsvd
         || !atsx_pkg::AW_OK_MASK[t.aw] || !atsx_pkg::TT_OK_MASK[t.tt]
         || (t.tt == atsx_pkg::TT_BLOCK);
   endfunction

   // verdict for one translated request
   function automatic atsx_pkg::atsx_verd_t verdict(input atsx_pkg::atsx_trq_t q,
                                                    input atsx_pkg::atsx_tchk_t t,
                                                    input logic remap);
      if (remap && q.pasid)
         verdict = atsx_pkg::V_MALF;
      else if (in_intr(q.addr) && (q.wr || q.atomic))
         verdict = atsx_pkg::V_UR;
      else if (in_intr(q.addr) && q.rd)
         verdict = atsx_pkg::V_UR;
      else if (remap && tbl_fail(t))
         verdict = atsx_pkg::V_FAULT;
      else
         verdict = atsx_pkg::V_PASS;
   endfunction

   // untranslated base of the page after the current one
   function automatic logic [63:0] next_page(input logic [63:0] a, input logic [5:0] sz);
      next_page = ((a >> sz) + 64'h1) << sz;
   endfunction

   // lowest free tag
   function automatic logic [atsx_pkg::TAG_W-1:0] low_free(input logic [NT-1:0] b);
      low_free = '0;
      for (int i = NT - 1; i >= 0; i--)
         if (!b[i])
            low_free = i[atsx_pkg::TAG_W-1:0];
   endfunction

   // per-tag ownership against the completion source
   genvar g;
   generate
      for (g = 0; g < NT; g++)
      begin : g_hit
         assign hit[g] = r_r.busy[g] && (r_r.own[g] == icpl.sid);
      end
   endgenerate
   assign bad = |(icpl.vec & ~hit);
   assign cc_eff = (icpl.cc == 3'h0) ? atsx_pkg::CC_ZERO_CNT : {1'b0, icpl.cc};

   // handshake and data outputs
   assign s_axi_awready = ce && !r_r.aw_v && !r_r.b_v;
   assign s_axi_wready = ce && !r_r.w_v && !r_r.b_v;
   assign s_axi_arready = ce && !r_r.r_v;
   assign s_axi_bvalid = r_r.b_v;
   assign s_axi_bresp = r_r.b_r;
   assign s_axi_rvalid = r_r.r_v;
   assign s_axi_rdata = r_r.r_d;
   assign s_axi_rresp = r_r.r_r;
   assign xreq_ready = ce && (r_r.xs == atsx_pkg::X_IDLE);
   assign look_valid = (r_r.xs == atsx_pkg::X_LOOK);
   assign look_addr = r_r.cur;
   assign ent_valid = (r_r.xs == atsx_pkg::X_ENT);
   assign ent = r_r.ent;
   assign hdr_valid = (r_r.xs == atsx_pkg::X_HDR);
   assign hdr = r_r.hdr;
   assign tv_valid = r_r.tv_v;
   assign tv_verdict = r_r.verd;
   assign fault_rec = r_r.frec;
   assign ireq_ready = ce && !r_r.mp && !(&r_r.busy);
   assign imsg_valid = r_r.mp;
   assign imsg = r_r.msg;
   assign done_vec = r_r.done;
   assign fault_event = r_r.fev;

   // next state of the whole block
   always_comb
   begin
      logic [2:0] clr;
      logic ice_set;
      logic ite_set;
      logic [atsx_pkg::TAG_W-1:0] fi;
      clr = 3'h0;
      ice_set = 1'b0;
      ite_set = 1'b0;
      fi = low_free(r_r.busy);
      r_nxt = r_r;
      r_nxt.tv_v = 1'b0;
      r_nxt.frec = 1'b0;
      r_nxt.done = '0;
      // register bus write side
      if (s_axi_awvalid && s_axi_awready)
      begin
         r_nxt.aw_v = 1'b1;
         r_nxt.aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         r_nxt.w_v = 1'b1;
         r_nxt.w_d = s_axi_wdata;
         r_nxt.w_s = s_axi_wstrb;
      end
      if (r_r.aw_v && r_r.w_v)
      begin
         r_nxt.aw_v = 1'b0;
         r_nxt.w_v = 1'b0;
         r_nxt.b_v = 1'b1;
         r_nxt.b_r = atsx_pkg::RESP_OKAY;
         case (r_r.aw_a)
            atsx_pkg::REG_CTRL:
               if (r_r.w_s[0])
                  r_nxt.ctrl = {29'h0, r_r.w_d[2:0]};
            atsx_pkg::REG_STAT:
               if (r_r.w_s[0])
                  clr = r_r.w_d[2:0];
            atsx_pkg::REG_TAGS:
               r_nxt.b_r = atsx_pkg::RESP_OKAY;
            default:
               r_nxt.b_r = atsx_pkg::RESP_SLVERR;
         endcase
      end
      if (r_r.b_v && s_axi_bready)
         r_nxt.b_v = 1'b0;
      // register bus read side
      if (r_r.r_v && s_axi_rready)
         r_nxt.r_v = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         r_nxt.r_v = 1'b1;
         r_nxt.r_r = atsx_pkg::RESP_OKAY;
         case (s_axi_araddr)
            atsx_pkg::REG_CTRL: r_nxt.r_d = r_r.ctrl;
            atsx_pkg::REG_STAT: r_nxt.r_d = {29'h0, r_r.tf, r_r.inval_timeout_error_flag, r_r.inval_completion_error_flag};
            atsx_pkg::REG_TAGS: r_nxt.r_d = {{(32 - NT){1'b0}}, r_r.busy};
            default:
            begin
               r_nxt.r_d = 32'h0;
               r_nxt.r_r = atsx_pkg::RESP_SLVERR;
            end
         endcase
      end
      // translation request sequencer
      case (r_r.xs)
         atsx_pkg::X_IDLE:
            if (xreq_valid)
            begin
               r_nxt.xs = atsx_pkg::X_LOOK;
               r_nxt.cur = xreq.addr;
               r_nxt.cnt = 4'h0;
               r_nxt.read_completion_boundary = xreq.read_completion_boundary;
               r_nxt.st = atsx_pkg::CPL_OK;
               r_nxt.sgl = !r_r.ctrl[atsx_pkg::CTRL_MULTI];
               if (r_r.ctrl[atsx_pkg::CTRL_MULTI] && (xreq.len_dw > atsx_pkg::SINGLE_LEN_DW))
                  r_nxt.want = {1'b0, xreq.len_dw[9:1]};
               else
                  r_nxt.want = 10'h001;
            end
         atsx_pkg::X_LOOK:
            if (look_ready)
               r_nxt.xs = atsx_pkg::X_WAIT;
         atsx_pkg::X_WAIT:
            if (look_rsp_valid)
            begin
               if (look_rsp.ca || look_rsp.ur)
               begin
                  r_nxt.xs = atsx_pkg::X_HDR;
                  if (r_r.cnt == 4'h0)
                     r_nxt.st = look_rsp.ca ? atsx_pkg::CPL_CA : atsx_pkg::CPL_UR;
               end
               else if ((r_r.cnt != 4'h0) && (look_rsp.size != r_r.ent.size))
                  r_nxt.xs = atsx_pkg::X_HDR;
               else
               begin
                  r_nxt.ent.taddr = look_rsp.taddr;
                  r_nxt.ent.size = look_rsp.size;
                  r_nxt.xs = atsx_pkg::X_ENT;
               end
            end
         atsx_pkg::X_ENT:
            if (ent_ready)
            begin
               r_nxt.cnt = r_r.cnt + 4'h1;
               r_nxt.cur = next_page(r_r.cur, r_r.ent.size);
               if (({6'h0, r_nxt.cnt} == r_r.want) || (r_nxt.cnt == atsx_pkg::LINE_ENTRIES))
                  r_nxt.xs = atsx_pkg::X_HDR;
               else
                  r_nxt.xs = atsx_pkg::X_LOOK;
            end
         atsx_pkg::X_HDR:
            if (hdr_ready)
               r_nxt.xs = atsx_pkg::X_IDLE;
         default:
            r_nxt.xs = atsx_pkg::X_IDLE;
      endcase
      r_nxt.hdr.st = r_nxt.st;
      r_nxt.hdr.len_dw = {5'h0, r_nxt.cnt, 1'b0};
      r_nxt.hdr.bcnt = {5'h0, r_nxt.cnt, 3'h0};
      r_nxt.hdr.low_addr = r_nxt.read_completion_boundary[6:0] - {r_nxt.cnt, 3'h0};
      // translated request check
      if (trq_valid)
      begin
         r_nxt.tv_v = 1'b1;
         r_nxt.verd = verdict(trq, tchk, r_r.ctrl[atsx_pkg::CTRL_REMAP]);
         r_nxt.frec = (r_nxt.verd == atsx_pkg::V_FAULT);
      end
      // tag allocation and message issue
      if (r_r.mp && imsg_ready)
         r_nxt.mp = 1'b0;
      if (ireq_valid && ireq_ready)
      begin
         r_nxt.busy[fi] = 1'b1;
         r_nxt.own[fi] = ireq.sid;
         r_nxt.icnt[fi] = 4'h0;
         r_nxt.tmr[fi] = TMO_CYCLES;
         r_nxt.mp = 1'b1;
         r_nxt.msg = '{tag: fi, sid: ireq.sid, pfx: ireq.first_level,
                       pasid: ireq.pasid, addr: ireq.addr};
      end
      // completion messages from the endpoint
      if (icpl_valid)
      begin
         if (bad)
            ice_set = 1'b1;
         else
            for (int i = 0; i < NT; i++)
               if (icpl.vec[i])
               begin
                  r_nxt.icnt[i] = r_r.icnt[i] + 4'h1;
                  if ((r_r.icnt[i] + 4'h1) == cc_eff)
                  begin
                     r_nxt.busy[i] = 1'b0;
                     r_nxt.done[i] = 1'b1;
                  end
               end
      end
      // completion timers
      for (int i = 0; i < NT; i++)
         if (r_r.busy[i] && !r_nxt.done[i])
         begin
            if (r_r.tmr[i] == 32'h1)
            begin
               r_nxt.busy[i] = 1'b0;
               ite_set = 1'b1;
            end
            else
               r_nxt.tmr[i] = r_r.tmr[i] - 32'h1;
         end
      // sticky flags, a new event beats a clear
      r_nxt.inval_completion_error_flag = (r_r.inval_completion_error_flag && !clr[0]) || ice_set;
      r_nxt.inval_timeout_error_flag = (r_r.inval_timeout_error_flag && !clr[1]) || ite_set;
      r_nxt.tf = (r_r.tf && !clr[2]) || r_nxt.frec;
      r_nxt.fev = r_r.ctrl[atsx_pkg::CTRL_FAULT] && (ice_set || ite_set || r_nxt.frec);
   end

   // state register, frozen while ce is low
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r_r <= '0;
         r_r.ctrl <= atsx_pkg::CTRL_RST;
      end
      else if (ce)
         r_r <= r_nxt;
   end

   // checks on own behaviour
   single_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (hdr_valid && r_r.sgl && (r_r.st == atsx_pkg::CPL_OK)) |->
      (hdr.len_dw == 10'h002) && (hdr.bcnt == 12'h008) && (hdr.low_addr == r_r.read_completion_boundary[6:0] - 7'h08))
      else $error("single completion header wrong");
   multi_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && xreq_valid && xreq_ready && r_r.ctrl[atsx_pkg::CTRL_MULTI] && (xreq.len_dw > 10'h002))
      |=> (r_r.want == {1'b0, $past(xreq.len_dw[9:1])}))
      else $error("multi request count wrong");
   ent_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ent_valid |-> (r_r.cnt < 4'h8))
      else $error("too many translations");
   malformed_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && trq_valid && trq.pasid && r_r.ctrl[atsx_pkg::CTRL_REMAP]) |=>
      (tv_valid && (tv_verdict == atsx_pkg::V_MALF) && !fault_rec))
      else $error("pasid translated request not malformed");
   intr_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && trq_valid && trq.rd && in_intr(trq.addr) && !trq.pasid) |=>
      (tv_verdict == atsx_pkg::V_UR))
      else $error("interrupt window read not ur");
   block_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && trq_valid && !trq.pasid && !in_intr(trq.addr) && r_r.ctrl[atsx_pkg::CTRL_REMAP])
      |=> (tv_verdict == ($past(tbl_fail(tchk)) ? atsx_pkg::V_FAULT : atsx_pkg::V_PASS))
      && (fault_rec == $past(tbl_fail(tchk))))
      else $error("table check verdict wrong");
   tag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (&r_r.busy) |-> !ireq_ready)
      else $error("request taken with no free tag");
   bad_tag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && icpl_valid && bad) |=> (r_r.inval_completion_error_flag && (r_r.busy == $past(r_r.busy))
      && (done_vec == '0)))
      else $error("bad completion not dropped");
   cnt_free_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && icpl_valid && !bad && icpl.vec[0] && (r_r.icnt[0] + 4'h1 == cc_eff)) |=>
      (!r_r.busy[0] && done_vec[0]))
      else $error("tag not freed on final completion");
   tmo_free_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && r_r.busy[0] && (r_r.tmr[0] == 32'h1) && !(icpl_valid && icpl.vec[0] && !bad))
      |=> (!r_r.busy[0] && r_r.inval_timeout_error_flag))
      else $error("time-out did not free tag");
endmodule

// >>> common/atsx_pkg.sv
// constants and carriers for the ats translation, check and invalidation block
package atsx_pkg;
   localparam int NTAG = 4;
   localparam int TAG_W = 2;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_TAGS = 8'h08;
   localparam int CTRL_REMAP = 0;
   localparam int CTRL_MULTI = 1;
   localparam int CTRL_FAULT = 2;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // translation completion, request check and completion count figures
   localparam logic [9:0] SINGLE_LEN_DW = 10'h002;
   localparam logic [3:0] LINE_ENTRIES = 4'h8;
   localparam logic [11:0] INTR_WIN = 12'hFEE;
   localparam logic [7:0] AW_OK_MASK = 8'h04;
   localparam logic [3:0] TT_OK_MASK = 4'h7;
   localparam logic [1:0] TT_BLOCK = 2'h0;
   localparam logic [3:0] CC_ZERO_CNT = 4'h8;
   // invalidation completion time-out
   localparam int CLK_MHZ = 50;
   localparam int INV_TMO_US = 200000;
   localparam int INV_TMO_CYC = INV_TMO_US * CLK_MHZ;

   typedef enum logic [2:0] {X_IDLE, X_LOOK, X_WAIT, X_ENT, X_HDR} atsx_xst_t;
   typedef enum logic [1:0] {CPL_OK, CPL_UR, CPL_CA} atsx_cst_t;
   typedef enum logic [1:0] {V_PASS, V_MALF, V_UR, V_FAULT} atsx_verd_t;
   typedef struct packed {logic [9:0] len_dw; logic [63:0] addr; logic [7:0] read_completion_boundary;} atsx_xreq_t;
   typedef struct packed {logic ca; logic ur; logic [5:0] size; logic [63:0] taddr;} atsx_lrsp_t;
   typedef struct packed {logic [63:0] taddr; logic [5:0] size;} atsx_ent_t;
   typedef struct packed
   {
      atsx_cst_t st;
      logic [9:0] len_dw;
      logic [11:0] bcnt;
      logic [6:0] low_addr;
   } atsx_hdr_t;
   typedef struct packed
   {
      logic pasid;
      logic wr;
      logic atomic;
      logic rd;
      logic [63:0] addr;
   } atsx_trq_t;
   typedef struct packed
   {
      logic root_err;
      logic root_present;
      logic root_rsvd;
      logic ctx_err;
      logic ctx_present;
      logic ctx_rsvd;
      logic [2:0] aw;
      logic [1:0] tt;
   } atsx_tchk_t;
   typedef struct packed
   {
      logic [15:0] sid;
      logic first_level;
      logic [19:0] pasid;
      logic [63:0] addr;
   } atsx_ireq_t;
   typedef struct packed
   {
      logic [TAG_W-1:0] tag;
      logic [15:0] sid;
      logic pfx;
      logic [19:0] pasid;
      logic [63:0] addr;
   } atsx_imsg_t;
   typedef struct packed {logic [15:0] sid; logic [NTAG-1:0] vec; logic [2:0] cc;} atsx_icpl_t;
endpackage

// >>> bench/atsx_ep.sv
// endpoint model that answers device-tlb invalidation messages
`timescale 1ns/10ps
module atsx_ep
(
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 mute,
   input  wire logic                 bad,
   input  wire logic                 imsg_valid,
   output logic                      imsg_ready,
   input  wire atsx_pkg::atsx_imsg_t imsg,
   output logic                      icpl_valid,
   output atsx_pkg::atsx_icpl_t      icpl
);
   logic [3:0]           dly_r;
   atsx_pkg::atsx_icpl_t pend_r;
   assign imsg_ready = 1'b1;
   // reply four cycles on; a wrong source id when bad is set
   always @(posedge aclk)
   begin
      dly_r <= {dly_r[2:0], imsg_valid & !mute};
      icpl_valid <= dly_r[3] & aresetn;
      icpl <= dly_r[3] ? pend_r : ~icpl; // idle lines toggle
      if (imsg_valid)
         pend_r <= '{imsg.sid ^ {15'h0, bad}, 4'(1 << imsg.tag), 3'h1};
      if (!aresetn)
      begin
         dly_r <= 4'h0;
         icpl <= '0;
      end
   end
endmodule

// >>> bench/tb.sv
// self-checking bench for the ats translation, check and invalidation block
`timescale 1ns/10ps
`define CHK(n, e, s) chk(n, 64'(e), 64'(s))
module tb;
   typedef struct packed
   {
      atsx_pkg::atsx_trq_t  q;
      atsx_pkg::atsx_tchk_t c;
      atsx_pkg::atsx_verd_t v;
   } atsx_row_t;
   logic aclk = 0, aresetn = 0, ce = 1, look_ready = 1, ent_ready = 1, hdr_ready = 1;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF, done_vec, dvec;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, xreq_valid = 0, xreq_ready, look_valid, look_rsp_valid = 0;
   logic ent_valid, hdr_valid, trq_valid = 0, tv_valid, fault_rec, ireq_valid = 0;
   logic ireq_ready, imsg_valid, imsg_ready, icpl_valid, fault_event, mute = 0, bad = 0;
   logic hdr_seen = 0, dn = 0, fe = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [63:0] look_addr, last_look;
   atsx_pkg::atsx_xreq_t xreq = '0;
   atsx_pkg::atsx_lrsp_t look_rsp = '0;
   atsx_pkg::atsx_ent_t ent;
   atsx_pkg::atsx_hdr_t hdr, hdr_s;
   atsx_pkg::atsx_trq_t trq = '0;
   atsx_pkg::atsx_tchk_t tchk = '0;
   atsx_pkg::atsx_verd_t tv_verdict;
   atsx_pkg::atsx_ireq_t ireq = '0;
   atsx_pkg::atsx_imsg_t imsg, msg_s;
   atsx_pkg::atsx_icpl_t icpl;
   int n_errors = 0, checked = 0, ent_n = 0, m;
   localparam atsx_row_t ROWS [9] = '{
      '{{4'h9, 64'h1000}, 11'h249, atsx_pkg::V_MALF},
      '{{4'h4, 64'hFEE0_0000}, 11'h249, atsx_pkg::V_UR},
      '{{4'h2, 64'hFEE1_0000}, 11'h249, atsx_pkg::V_UR},
      '{{4'h1, 64'hFEEF_0000}, 11'h249, atsx_pkg::V_UR},
      '{{4'h4, 64'h1000}, 11'h649, atsx_pkg::V_FAULT},
      '{{4'h4, 64'h1000}, 11'h209, atsx_pkg::V_FAULT},
      '{{4'h4, 64'h1000}, 11'h24D, atsx_pkg::V_FAULT},
      '{{4'h4, 64'h1000}, 11'h248, atsx_pkg::V_FAULT},
      '{{4'h4, 64'h1000}, 11'h249, atsx_pkg::V_PASS}};
   atsx_top #(.TMO_CYCLES(32'h32)) dut_u (.*);
   atsx_ep ep_u (.*);
   always #10 aclk = ~aclk;
   // lookup answers a 4 KiB page; capture of outputs
   always @(posedge aclk)
   begin
      look_rsp_valid <= look_valid;
      look_rsp <= '{1'b0, 1'b0, 6'hC, look_addr ^ 64'hA000_0000};
      if (look_valid)
         last_look <= look_addr;
      if (ent_valid)
         ent_n <= ent_n + 1;
      if (hdr_valid)
         {hdr_seen, hdr_s} <= {1'b1, hdr};
      if (done_vec != 4'h0)
         {dn, dvec} <= {1'b1, done_vec};
      if (imsg_valid)
         msg_s <= imsg;
      if (fault_event)
         fe <= 1'b1;
   end
   task automatic end_sim();
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tmo();
      n_errors++;
      $display("CHECK FAILED wait exp answer got none");
      end_sim();
   endtask
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
      checked++;
      if (s !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s exp %0h got %0h", n, e, s);
      end
   endtask
   // wait for a ready sampled high at an edge
   task automatic hs(ref logic rdy);
      for (int j = 0; j < 300; j++)
      begin
         @(posedge aclk);
         if (rdy === 1'b1)
            return;
      end
      tmo();
   endtask
   task automatic wt(ref logic s, input int lim);
      for (int j = 0; j <= lim; j++)
      begin
         if (s === 1'b1)
            return;
         @(posedge aclk);
         #1;
      end
      tmo();
   endtask
   // axi4-lite write and read, each held until taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (i = 0; i < 40 && !(s_axi_bvalid === 1'b1 && !s_axi_awvalid); i++)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         rsp = s_axi_bresp;
      end
      s_axi_bready <= 1'b0;
      if (i == 40)
         tmo();
   endtask
   task automatic axr(input logic [7:0] a);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (i = 0; i < 40 && !(s_axi_rvalid === 1'b1 && !s_axi_arvalid); i++)
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         {rsp, rd} = {s_axi_rresp, s_axi_rdata};
      end
      s_axi_rready <= 1'b0;
      if (i == 40)
         tmo();
   endtask
   task automatic inv(input logic [15:0] s);
      @(posedge aclk);
      {ireq_valid, ireq} <= {1'b1, s, 1'b1, 20'h00ABC, 64'h2000};
      hs(ireq_ready);
      ireq_valid <= 1'b0;
   endtask
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (ROWS[k])
      begin
         @(posedge aclk);
         {trq_valid, trq, tchk} <= {1'b1, ROWS[k].q, ROWS[k].c};
         @(posedge aclk);
         trq_valid <= 1'b0;
         #1;
         wt(tv_valid, 3);
         `CHK("verdict", ROWS[k].v, tv_verdict);
         `CHK("fault_rec", ROWS[k].v == atsx_pkg::V_FAULT, fault_rec);
      end
      $display("test checker rows done");
      for (m = 0; m < 2; m++)
      begin
         axw(atsx_pkg::REG_CTRL, {30'h0, m[0], 1'b1});
         ent_n = 0;
         hdr_seen = 0;
         @(posedge aclk);
         {xreq_valid, xreq} <= {1'b1, 10'h14, 64'h4000, 8'h40};
         hs(xreq_ready);
         xreq_valid <= 1'b0;
         wt(hdr_seen, 100);
         `CHK("entries", m ? 8 : 1, ent_n);
         `CHK("hdr len", m ? 16 : 2, hdr_s.len_dw);
         `CHK("hdr st", atsx_pkg::CPL_OK, hdr_s.st);
         `CHK("hdr bcnt", m ? 64 : 8, hdr_s.bcnt);
         `CHK("hdr low", m ? 0 : 56, hdr_s.low_addr);
         `CHK("last look", m ? 64'hB000 : 64'h4000, last_look);
      end
      $display("test translation completion done");
      inv(16'h0011);
      wt(dn, 20);
      `CHK("done tag", 4'h1, dvec);
      `CHK("pasid prefix", {1'b1, 20'h00ABC}, {msg_s.pfx, msg_s.pasid});
      mute <= 1'b1;
      for (m = 0; m < 4; m++)
         inv(16'h0022);
      axr(atsx_pkg::REG_TAGS);
      `CHK("tags busy", 32'hF, rd);
      inv(16'h0022);
      repeat (2) @(posedge aclk);
      `CHK("reused tag", 2'h0, msg_s.tag);
      repeat (60) @(posedge aclk);
      axr(atsx_pkg::REG_STAT);
      `CHK("timeout flag", 32'h6, rd);
      axw(atsx_pkg::REG_STAT, 32'h7);
      axw(atsx_pkg::REG_CTRL, 32'h5);
      {mute, bad, dn} <= 3'h2;
      inv(16'h0033);
      repeat (12) @(posedge aclk);
      axr(atsx_pkg::REG_STAT);
      `CHK("cpl error", 32'h1, rd);
      `CHK("dropped", 2'h1, {dn, fe});
      axr(8'h40);
      `CHK("unmapped", atsx_pkg::RESP_SLVERR, rsp);
      $display("test invalidation done");
      end_sim();
   end
endmodule
